// >>> src/backup_power_switchover.sv
// Backup power switchover controller with APB registers and shared irq/clock pin.
// Assumes analog comparators drive the supply indications and reset is power-on.
`timescale 1ns/1ps
module backup_power_switchover
  import power_switch_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic below_backup_raw,
  input wire logic below_trip_raw,
  input wire logic above_backup_raw,
  input wire logic above_trip_raw,
  input wire logic total_loss_at_por,
  input wire logic osc_input,
  input wire logic osc_external,
  output logic osc_output,
  input wire logic alarm_event,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_drive_low,
  output logic scl_gated,
  output logic sda_gated,
  output logic sda_oe,
  output logic sda_out,
  output logic backup_select,
  output logic irq_or_freq_pin_out,
  output logic irq_or_freq_pin_oe,
  output logic irq
);
  import power_switch_pkg::*;

  logic below_backup;
  logic below_trip;
  logic above_backup;
  logic above_trip;
  logic [3:0] raw_vec;
  logic [3:0] clean_vec;
  power_state_t state_reg;
  power_state_t state_next;
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic [ev_count-1:0] ist_reg;
  logic [ev_count-1:0] ist_next;
  logic [ev_count-1:0] ien_reg;
  logic [ev_count-1:0] ien_next;
  logic loss_reg;
  logic loss_next;
  logic ovr_reg;
  logic ovr_next;
  logic por_pending_reg;
  logic por_pending_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [15:0] fcnt_reg;
  logic [15:0] fcnt_next;
  logic fclk_reg;
  logic fclk_next;
  logic irq_reg;
  logic irq_next;
  logic pin_oe_reg;
  logic pin_oe_next;
  logic scl_reg;
  logic scl_next;
  logic sda_reg;
  logic sda_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic osc_reg;
  logic osc_next;
  logic [2:0] osc_sync_reg;
  logic [2:0] osc_sync_next;
  logic wr;
  logic rd;
  logic in_backup;
  logic [ev_count-1:0] events;

  assign raw_vec = {above_trip_raw, above_backup_raw, below_trip_raw, below_backup_raw};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_filter
      input_filter u_filter
      (
        .clock(clock),
        .srst(srst),
        .raw(raw_vec[gi]),
        .clean(clean_vec[gi])
      );
    end
  endgenerate

  assign below_backup = clean_vec[0];
  assign below_trip = clean_vec[1];
  assign above_backup = clean_vec[2];
  assign above_trip = clean_vec[3];
  assign wr = psel && penable && pwrite;
  // Read data are loaded in the setup cycle so they stand through the access phase.
  assign rd = psel && !penable && !pwrite;
  assign in_backup = (state_reg == st_backup);

  always_comb
  begin
    state_next = state_reg;
    events = '0;
    case (state_reg)
      st_unarmed:
      begin
        if (above_backup || above_trip)
        begin
          state_next = st_main;
        end
      end
      st_main:
      begin
        if (ctrl_reg[ctrl_direct_bit])
        begin
          if (below_backup)
          begin
            state_next = st_backup;
          end
        end
        else if (below_backup && below_trip)
        begin
          state_next = st_backup;
        end
        events[ev_to_backup] = (state_next == st_backup);
      end
      st_backup:
      begin
        if (above_backup || (above_trip && !ctrl_reg[ctrl_direct_bit]))
        begin
          state_next = st_main;
          events[ev_to_main] = 1'b1;
        end
      end
      default:
      begin
        state_next = st_unarmed;
      end
    endcase
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    div_next = div_reg;
    ien_next = ien_reg;
    ist_next = ist_reg;
    ovr_next = ovr_reg;
    loss_next = loss_reg;
    por_pending_next = 1'b0;
    prdata_next = prdata_reg;
    if (wr)
    begin
      case (paddr)
        ctrl_off:
        begin
          ctrl_next = pwdata & 32'h0000_003f;
          if (pwdata[ctrl_loss_clr_bit])
          begin
            loss_next = 1'b0;
          end
        end
        div_off: div_next = pwdata[15:0];
        int_en_off: ien_next = pwdata[ev_count-1:0];
        int_clr_off: ist_next = ist_reg & ~pwdata[ev_count-1:0];
        default: ovr_next = ovr_reg;
      endcase
    end
    // Catch strap after reset release; the set outranks a clear.
    if (por_pending_reg && total_loss_at_por)
    begin
      loss_next = 1'b1;
    end
    // Events are applied after the clear so that a set in the same cycle wins.
    ist_next = ist_next | events;
    if ((ist_reg & events) != '0)
    begin
      ovr_next = 1'b1;
    end
    if (rd)
    begin
      case (paddr)
        ctrl_off: prdata_next = ctrl_reg;
        stat_off: prdata_next = {28'h000_0000, ovr_reg, (state_reg != st_unarmed),
          loss_reg, in_backup};
        int_stat_off: prdata_next = {30'h0000_0000, ist_reg};
        int_en_off: prdata_next = {30'h0000_0000, ien_reg};
        div_off: prdata_next = {16'h0000, div_reg};
        default: prdata_next = zero_word;
      endcase
    end
  end

  always_comb
  begin
    fcnt_next = fcnt_reg;
    fclk_next = fclk_reg;
    irq_next = (ist_reg & ien_reg) != '0;
    pin_oe_next = 1'b0;
    osc_sync_next = {osc_sync_reg[1:0], osc_input};
    osc_next = osc_external ? 1'b0 : !osc_input;
    if (fcnt_reg >= div_reg)
    begin
      fcnt_next = 16'h0000;
      fclk_next = !fclk_reg;
    end
    else
    begin
      fcnt_next = fcnt_reg + 16'h0001;
    end
    if (ctrl_reg[ctrl_pin_mode_bit])
    begin
      if (ctrl_reg[ctrl_freq_en_bit] && (!in_backup || ctrl_reg[ctrl_freq_batt_en_bit]))
      begin
        pin_oe_next = !fclk_reg;
      end
    end
    else if (ctrl_reg[ctrl_alarm_bit] && alarm_event)
    begin
      pin_oe_next = !in_backup || ctrl_reg[ctrl_irq_batt_en_bit];
    end
    scl_next = in_backup ? 1'b1 : scl_in;
    sda_next = in_backup ? 1'b1 : sda_in;
    sda_oe_next = !in_backup && sda_drive_low;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_reg <= st_unarmed;
      ctrl_reg <= ctrl_reset;
      div_reg <= div_reset;
      ien_reg <= '0;
      ist_reg <= '0;
      ovr_reg <= 1'b0;
      loss_reg <= 1'b0;
      por_pending_reg <= 1'b1;
      prdata_reg <= zero_word;
      fcnt_reg <= 16'h0000;
      fclk_reg <= 1'b0;
      irq_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
      osc_reg <= 1'b0;
      osc_sync_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      div_reg <= div_next;
      ien_reg <= ien_next;
      ist_reg <= ist_next;
      ovr_reg <= ovr_next;
      loss_reg <= loss_next;
      por_pending_reg <= por_pending_next;
      prdata_reg <= prdata_next;
      fcnt_reg <= fcnt_next;
      fclk_reg <= fclk_next;
      irq_reg <= irq_next;
      pin_oe_reg <= pin_oe_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      sda_oe_reg <= sda_oe_next;
      osc_reg <= osc_next;
      osc_sync_reg <= osc_sync_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign backup_select = state_reg[2];
  assign irq = irq_reg;
  assign irq_or_freq_pin_out = 1'b0;
  assign irq_or_freq_pin_oe = pin_oe_reg;
  assign scl_gated = scl_reg;
  assign sda_gated = sda_reg;
  assign sda_oe = sda_oe_reg;
  assign sda_out = 1'b0;
  assign osc_output = osc_reg;
endmodule : backup_power_switchover

// >>> src/power_switch_pkg.sv
// Package for the backup power switchover block: register map, fields, timing.
// Assumes a single 50 MHz clock and an APB register bus.
package power_switch_pkg;
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] stat_off = 12'h004;
  localparam logic [11:0] int_stat_off = 12'h008;
  localparam logic [11:0] int_en_off = 12'h00c;
  localparam logic [11:0] int_clr_off = 12'h010;
  localparam logic [11:0] div_off = 12'h014;
  // Control fields.
  localparam int ctrl_direct_bit = 0;
  localparam int ctrl_pin_mode_bit = 1;
  localparam int ctrl_freq_en_bit = 2;
  localparam int ctrl_irq_batt_en_bit = 3;
  localparam int ctrl_freq_batt_en_bit = 4;
  localparam int ctrl_alarm_bit = 5;
  localparam int ctrl_loss_clr_bit = 6;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [15:0] div_reset = 16'h0000;
  // Status fields.
  localparam int stat_backup_bit = 0;
  localparam int stat_loss_bit = 1;
  localparam int stat_armed_bit = 2;
  localparam int stat_ovr_bit = 3;
  // Interrupt events.
  localparam int ev_to_backup = 0;
  localparam int ev_to_main = 1;
  localparam int ev_count = 2;
  // Debounce time of comparator indications.
  localparam int clk_mhz = 50;
  localparam int debounce_us = 20;
  localparam int debounce_cycles = debounce_us * clk_mhz;
  localparam int sync_stages = 3;
  localparam logic [31:0] zero_word = 32'h0000_0000;
  typedef enum logic [2:0]
  {
    st_unarmed = 3'b001,
    st_main = 3'b010,
    st_backup = 3'b100
  } power_state_t;
endpackage : power_switch_pkg

// >>> src/input_filter.sv
// Three-stage synchroniser with agreement check and debounce counter.
// Assumes a free-running clock; the raw input may be fully asynchronous.
`timescale 1ns/1ps
module input_filter
  import power_switch_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic raw,
  output logic clean
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  logic clean_reg;
  logic clean_next;
  localparam logic [10:0] cnt_max = 11'(debounce_cycles);

  always_comb
  begin
    sync_next = {sync_reg[1:0], raw};
    cnt_next = cnt_reg;
    clean_next = clean_reg;
    // Only stages two and three are compared; stage one feeds stage two alone.
    if ((sync_reg[1] != sync_reg[2]) || (sync_reg[2] == clean_reg))
    begin
      cnt_next = 11'h000;
    end
    else if (cnt_reg == cnt_max - 11'h001)
    begin
      cnt_next = 11'h000;
      clean_next = sync_reg[2];
    end
    else
    begin
      cnt_next = cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      sync_reg <= 3'h0;
      cnt_reg <= 11'h000;
      clean_reg <= 1'b0;
    end
    else
    begin
      sync_reg <= sync_next;
      cnt_reg <= cnt_next;
      clean_reg <= clean_next;
    end
  end

  assign clean = clean_reg;
endmodule : input_filter

// >>> tb/switchover_properties.sv
// Checker on the pins of the switchover block.
// Assumes it is bound to the top module and one clock domain.
`timescale 1ns/1ps
module switchover_properties
(
  input wire logic clock,
  input wire logic srst,
  input wire logic below_backup_raw,
  input wire logic above_backup_raw,
  input wire logic above_trip_raw,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_drive_low,
  input wire logic scl_gated,
  input wire logic sda_gated,
  input wire logic sda_oe,
  input wire logic backup_select,
  input wire logic irq_or_freq_pin_out,
  input wire logic irq_or_freq_pin_oe,
  input wire logic osc_input,
  input wire logic osc_external,
  input wire logic osc_output,
  input wire logic irq
);
  logic [15:0] lo_cnt;
  logic [15:0] hi_cnt;
  logic seen_main;
  logic scl_d;
  logic sda_d;
  logic drv_d;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Counters restart with reset because the block's debounce does too.
  always_ff @(posedge clock)
  begin
    scl_d <= scl_in;
    sda_d <= sda_in;
    drv_d <= sda_drive_low;
    lo_cnt <= (below_backup_raw && !srst) ? lo_cnt + {15'h0, ~&lo_cnt} : 16'h0000;
    hi_cnt <= (above_backup_raw && !srst) ? hi_cnt + {15'h0, ~&hi_cnt} : 16'h0000;
    seen_main <= !srst && (seen_main || above_backup_raw || above_trip_raw);
  end
  property p_settle;
    $rose(backup_select) |-> lo_cnt >= 16'h03e8;
  endproperty
  a_settle: assert property (p_settle) else $error("early backup entry");
  property p_armed;
    $rose(backup_select) |-> seen_main;
  endproperty
  a_armed: assert property (p_armed) else $error("backup before main");
  property p_return;
    hi_cnt >= 16'h03fc |-> !backup_select;
  endproperty
  a_return: assert property (p_return) else $error("no return to main");
  // The gated pins follow the state one edge later.
  property p_gated;
    backup_select ##1 backup_select |-> scl_gated && sda_gated;
  endproperty
  a_gated: assert property (p_gated) else $error("serial inputs pass in backup");
  property p_undriven;
    backup_select ##1 backup_select |-> !sda_oe;
  endproperty
  a_undriven: assert property (p_undriven) else $error("data driven in backup");
  property p_pass;
    !srst && !backup_select |=> {scl_gated, sda_gated, sda_oe} == {scl_d, sda_d, drv_d};
  endproperty
  a_pass: assert property (p_pass) else $error("serial pins blocked in main");
  property p_pin_low;
    irq_or_freq_pin_oe |-> !irq_or_freq_pin_out;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("shared pin driven high");
  property p_osc;
    !srst |=> osc_output == (!$past(osc_external) && !$past(osc_input));
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator output wrong");
  cover property ($rose(backup_select));
  cover property ($fell(backup_select));
  cover property ($rose(irq));
endmodule : switchover_properties
bind backup_power_switchover switchover_properties chk
(
  .clock, .srst, .below_backup_raw, .above_backup_raw, .above_trip_raw,
  .scl_in, .sda_in, .sda_drive_low, .scl_gated, .sda_gated, .sda_oe,
  .backup_select, .irq_or_freq_pin_out, .osc_input, .osc_external,
  .osc_output, .irq, .irq_or_freq_pin_oe
);

// >>> tb/supply_model.sv
// Comparator model: turns a supply level code into the four indications.
// Assumes the bench changes the level just after a rising edge.
`timescale 1ns/1ps
module supply_model
(
  input wire logic [1:0] level,
  output logic below_backup_raw,
  output logic below_trip_raw,
  output logic above_backup_raw,
  output logic above_trip_raw
);
  // Level 0: no main; 1: main between trip and battery; 2: main above both.
  // The hysteresis band is not modelled, so no level shows neither side.
  // Below and above indications.
  assign below_backup_raw = (level != 2'h2);
  assign below_trip_raw = (level == 2'h0);
  assign above_backup_raw = (level == 2'h2);
  assign above_trip_raw = (level != 2'h0);
endmodule : supply_model

// >>> tb/backup_power_switchover_test.sv
// Bench: APB master, comparator model and pin checks for the switchover block.
// Assumes the register map and debounce time of the design's package.
`timescale 1ns/1ps
module backup_power_switchover_test;
  import power_switch_pkg::*;
  typedef struct { logic [11:0] a; logic [31:0] v; } row_t;
  logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, osc_output, scl_gated, sda_gated, sda_oe, sda_out;
  logic backup_select, irq_or_freq_pin_out, irq_or_freq_pin_oe, irq, p;
  logic below_backup_raw, below_trip_raw, above_backup_raw, above_trip_raw;
  logic total_loss_at_por = 1, osc_input = 0, osc_external = 0, alarm_event = 0;
  logic scl_in = 1, host_sda = 1, sda_drive_low = 0;
  logic [1:0] level = 2'h0;
  int cycles = 0, n_fail = 0, compares = 0, k;
  wire sda_in = host_sda & ~(sda_oe & ~sda_out);
  // The shared pin is open drain with a pull-up.
  wire pin_level = irq_or_freq_pin_oe ? irq_or_freq_pin_out : 1'h1;
  row_t rows [6] = '{'{ctrl_off, ctrl_reset}, '{stat_off, 32'h0000_0002},
    '{int_stat_off, zero_word}, '{int_en_off, zero_word}, '{div_off, zero_word},
    '{12'h020, zero_word}};
  backup_power_switchover uut (.*);
  supply_model far (.*);
  initial forever #10 clock = ~clock;
  task conclude();
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    osc_input <= ~osc_input;
    if (cycles == 40000)
    begin
      n_fail = n_fail + 1;
      conclude();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Read data stand through the access phase and are taken at the completing edge.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'h1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wait_sel(input logic v);
    repeat (1100) if (backup_select !== v) @(posedge clock);
    check(backup_select, v);
    // The registered interrupt follows the state change one edge later.
    @(posedge clock);
  endtask : wait_sel
  initial
  begin
    repeat (8) @(posedge clock);
    srst <= 0;
    foreach (rows[i])
    begin
      apb(0, rows[i].a, zero_word);
      check(rd, rows[i].v);
    end
    repeat (1100) @(posedge clock);
    check(backup_select, 0);
    level <= 2'h2;
    repeat (1100) @(posedge clock);
    apb(0, stat_off, zero_word);
    check(rd, 32'h0000_0006);
    apb(1, ctrl_off, 32'h0000_0040);
    apb(0, stat_off, zero_word);
    check(rd, 32'h0000_0004);
    apb(1, int_en_off, 32'h0000_0003);
    level <= 2'h1;
    repeat (1100) @(posedge clock);
    check(backup_select, 0);
    level <= 2'h0;
    wait_sel(1);
    check(irq, 1);
    apb(1, int_clr_off, 32'h0000_0001);
    repeat (2) @(posedge clock);
    check(irq, 0);
    scl_in <= 0;
    host_sda <= 0;
    sda_drive_low <= 1;
    alarm_event <= 1;
    apb(1, ctrl_off, 32'h0000_0028);
    repeat (2) @(posedge clock);
    check({scl_gated, sda_gated, sda_oe}, 3'h6);
    check(pin_level, 0);
    apb(1, ctrl_off, 32'h0000_0020);
    repeat (2) @(posedge clock);
    check(pin_level, 1);
    alarm_event <= 0;
    scl_in <= 1;
    host_sda <= 1;
    sda_drive_low <= 0;
    level <= 2'h1;
    wait_sel(0);
    check(irq, 1);
    apb(1, int_clr_off, 32'h0000_0003);
    apb(1, int_en_off, 32'h0000_0002);
    apb(1, ctrl_off, 32'h0000_0001);
    wait_sel(1);
    check(irq, 0);
    repeat (1100) @(posedge clock);
    check(backup_select, 1);
    level <= 2'h2;
    wait_sel(0);
    check(irq, 1);
    apb(1, div_off, 32'h0000_0001);
    apb(1, ctrl_off, 32'h0000_0006);
    // The pin takes the clock function one edge after the write.
    repeat (2) @(posedge clock);
    k = 0;
    repeat (8)
    begin
      p = pin_level;
      @(posedge clock);
      k += (pin_level != p);
    end
    check(k, 4);
    osc_external <= 1;
    repeat (2) @(posedge clock);
    check(osc_output, 0);
    osc_external <= 0;
    total_loss_at_por <= 0;
    srst <= 1;
    repeat (8) @(posedge clock);
    srst <= 0;
    apb(0, stat_off, zero_word);
    check(rd, zero_word);
    apb(0, ctrl_off, zero_word);
    check(rd, ctrl_reset);
    conclude();
  end
endmodule : backup_power_switchover_test
